// ### diag_map.vh
// Register offsets, field positions and timing constants for the fault supervisor.
// Included by the main design file and the bench; holds definitions only.
`ifndef DIAG_MAP_VH
`define DIAG_MAP_VH
`define REG_TEST_CTRL 6'h10
`define REG_MARGIN_FAIL 6'h11
`define REG_ECC_FAIL 6'h12
// Test control fields
`define FLD_MARGIN_RUN 0
`define FLD_SCOPE_LO 1
`define FLD_SCOPE_HI 2
// Margin scope encodings
`define SCOPE_BOTH 2'h0
`define SCOPE_ONES 2'h1
`define SCOPE_ZEROS 2'h2
// Timing figures in microseconds, clock in MHz, and the delays converted to cycles
`define OUTPUT_ENABLE_DELAY_US 125
`define POWER_ON_SETTLE_US 125
`define CLK_MHZ 250
`define OUTPUT_ENABLE_DELAY_CYC (`OUTPUT_ENABLE_DELAY_US * `CLK_MHZ)
`define POWER_ON_SETTLE_CYC (`POWER_ON_SETTLE_US * `CLK_MHZ)
`endif

// ### config_mem.v
// Configuration word store with a registered read port.
// Assumes one clock; writes come from the serial programming path outside.
`timescale 1ns/1ps
`default_nettype none
module config_mem #(
  parameter AW = 6,
  parameter DW = 30
) (
  input wire core_clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Registered read, so the checker sees a stable word
  always @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // config_mem
`default_nettype wire

// ### sensor_fault_diagnostics.v
// Digital fault supervisor: supply and ground diagnostics, memory ECC, margin test.
// Assumes comparator levels and register port signals are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "diag_map.vh"

// What this block does
// R01: A single flipped bit in a memory word is corrected before use.
// R02: Two flipped bits raise a fault and float the output.
// R03: Single or dual errors set a readable diagnostic flag.
// R04: Writing one to margin run starts a margin test over all memory.
// R05: Margin test results land in the margin-fail and ECC-fail registers.
// R06: Margin scope selects ones only, zeros only, or both.
// R07: Margin controls work under customer write access as well as factory.
// R08: Margin failures go only to status, never to the output.
// R09: Undervoltage active forces the diagnostic high level.
// R10: After undervoltage clears, release follows the power-on settle time.
// R11: Overvoltage active forces the diagnostic high level.
// R12: After overvoltage clears, release follows the output enable delay.
// R13: Broken ground forces the diagnostic high level.
// R14: Output enable delay is 125 microseconds.
// R15: Uncorrectable memory fault floats output over any diagnostic drive.
// R16: Margin run bit stays set during the test, clears when results written.
module sensor_fault_diagnostics #(
  parameter AW = 6,
  parameter WORDS = 64,
  parameter [23:0] OV_DELAY = `OUTPUT_ENABLE_DELAY_CYC,
  parameter [23:0] UV_DELAY = `POWER_ON_SETTLE_CYC
) (
  input wire core_clk,
  input wire rst,
  input wire undervoltage_det,
  input wire overvoltage_det,
  input wire ground_open_det,
  input wire customer_access,
  input wire factory_access,
  input wire mem_we,
  input wire [AW-1:0] mem_waddr,
  input wire [29:0] mem_wdata,
  input wire [AW-1:0] cfg_addr,
  input wire reg_we,
  input wire [5:0] reg_addr,
  input wire [23:0] reg_wdata,
  output reg [23:0] reg_rdata,
  output reg [23:0] cfg_data,
  output reg diag_force_high,
  output reg output_hiz,
  output reg ecc_flag
);
  // ****************************************
  // Storage and ECC decode
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_CHECK = 2'h2;
  localparam ST_DONE = 2'h3;
  reg [1:0] state_q;
  reg [AW-1:0] scan_q;
  reg [AW-1:0] prev_scan_q;
  reg [1:0] scope_q;
  reg [23:0] mfail_q;
  reg [23:0] efail_q;
  reg [AW-1:0] mraddr;
  wire [29:0] word;
  wire [5:0] syn;
  reg [23:0] fixed;
  reg [29:0] flip;
  wire [28:0] hit;
  reg sense_live_q;

  // Code position of word bit bit_idx: data on the non-powers of two, check bit j on 2**j
  function [4:0] pos_of;
    input integer bit_idx;
    integer p;
    integer n;
    begin
      pos_of = 5'd0;
      n = 0;
      if (bit_idx >= 24) begin
        pos_of = 5'd1 << (bit_idx - 24);
      end else begin
        for (p = 1; p < 30; p = p + 1) begin
          if ((p & (p - 1)) != 0) begin
            if (n == bit_idx) begin
              pos_of = p[4:0];
            end
            n = n + 1;
          end
        end
      end
    end
  endfunction

  config_mem #(.AW(AW), .DW(30)) config_mem_i (
    .core_clk(core_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mraddr),
    .rdata(word)
  );

  // Scan address while testing, otherwise the sensing path
  always @* begin
    mraddr = (state_q == ST_IDLE) ? cfg_addr : scan_q;
  end

  // Hamming syndrome over 29 coded positions plus overall parity bit 29
  // Check bits must sit on powers of two, else not every data word is encodable
  genvar g;
  genvar k;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_syn
      wire [28:0] sel;
      for (k = 0; k < 29; k = k + 1) begin : g_k
        localparam [4:0] POS = pos_of(k);
        assign sel[k] = POS[g] ? word[k] : 1'b0;
      end
      assign syn[g] = ^sel;
    end
  endgenerate
  assign syn[5] = ^word;

  wire single_err = syn[5] && (syn[4:0] != 5'h00);
  wire dual_err = !syn[5] && (syn[4:0] != 5'h00);
  wire par_only = syn[5] && (syn[4:0] == 5'h00);

  // One match per bit; syndromes 30 and 31 match nothing and are only flagged
  generate
    for (k = 0; k < 29; k = k + 1) begin : g_fix
      localparam [4:0] POS = pos_of(k);
      assign hit[k] = single_err && (syn[4:0] == POS); // R01
    end
  endgenerate

  // Correct the flipped position, then pull out the 24 data positions
  always @* begin
    flip = word ^ {1'b0, hit}; // R01
    fixed = flip[23:0];
  end

  // Read port shows the scan address for a cycle after a margin run ends
  always @(posedge core_clk) begin
    if (rst) begin
      sense_live_q <= 1'b0;
    end else begin
      sense_live_q <= (state_q == ST_IDLE);
    end
  end

  // ****************************************
  // Sensing path, flag and memory fault
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      cfg_data <= 24'h0000_0000;
      ecc_flag <= 1'b0;
      output_hiz <= 1'b0;
    end else if (state_q == ST_IDLE && sense_live_q) begin
      cfg_data <= fixed; // R01
      if (single_err || par_only || dual_err) begin
        ecc_flag <= 1'b1; // R03
      end
      if (dual_err) begin
        output_hiz <= 1'b1; // R02 R15
      end
    end
  end

  // ****************************************
  // Supply and ground diagnostics
  // ****************************************
  reg [23:0] uv_cnt_q;
  reg [23:0] ov_cnt_q;
  always @(posedge core_clk) begin
    if (rst) begin
      uv_cnt_q <= 24'h0000_0000;
      ov_cnt_q <= 24'h0000_0000;
      diag_force_high <= 1'b0;
    end else begin
      if (undervoltage_det) begin
        uv_cnt_q <= UV_DELAY; // R09
      end else if (uv_cnt_q != 24'h0000_0000) begin
        uv_cnt_q <= uv_cnt_q - 24'h0000_0001; // R10
      end
      if (overvoltage_det) begin
        ov_cnt_q <= OV_DELAY; // R11 R14
      end else if (ov_cnt_q != 24'h0000_0000) begin
        ov_cnt_q <= ov_cnt_q - 24'h0000_0001; // R12
      end
      // Hi-Z wins, margin results never reach here
      diag_force_high <= !output_hiz && (undervoltage_det || overvoltage_det ||
        ground_open_det || uv_cnt_q > 24'h0000_0001 || ov_cnt_q > 24'h0000_0001); // R13 R15 R08
    end
  end

  // ****************************************
  // Margin test sequencer and registers
  // ****************************************
  wire access_ok = customer_access || factory_access; // R07
  wire run_req = reg_we && access_ok && (reg_addr == `REG_TEST_CTRL) &&
    reg_wdata[`FLD_MARGIN_RUN];
  wire ones_on = scope_q != `SCOPE_ZEROS;
  wire zeros_on = scope_q != `SCOPE_ONES;

  always @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      scan_q <= {AW{1'b0}};
      prev_scan_q <= {AW{1'b0}};
      scope_q <= `SCOPE_BOTH;
      mfail_q <= 24'h0000_0000;
      efail_q <= 24'h0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (run_req) begin
            scope_q <= reg_wdata[`FLD_SCOPE_HI:`FLD_SCOPE_LO]; // R06
            scan_q <= {AW{1'b0}};
            state_q <= ST_READ; // R04
          end
        end
        ST_READ: begin
          prev_scan_q <= scan_q;
          state_q <= ST_CHECK;
        end
        ST_CHECK: begin
          // Weak cells: a stored one that reads low, or a stored zero that reads high
          if ((ones_on && |(flip[23:0] & ~word[23:0])) ||
              (zeros_on && |(~flip[23:0] & word[23:0]))) begin
            mfail_q[prev_scan_q % 24] <= 1'b1; // R06
          end
          if (single_err || dual_err || par_only) begin
            efail_q[prev_scan_q % 24] <= 1'b1;
          end
          if (scan_q == WORDS - 1) begin
            state_q <= ST_DONE;
          end else begin
            scan_q <= scan_q + 1'b1;
            state_q <= ST_READ;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE; // R05 R16
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Readback; run bit reflects a busy sequencer
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 24'h0000_0000;
    end else begin
      case (reg_addr)
        `REG_TEST_CTRL: reg_rdata <= {21'h00_0000, scope_q, state_q != ST_IDLE}; // R16
        `REG_MARGIN_FAIL: reg_rdata <= mfail_q; // R05
        `REG_ECC_FAIL: reg_rdata <= efail_q; // R05
        default: reg_rdata <= 24'h0000_0000;
      endcase
    end
  end
endmodule // sensor_fault_diagnostics
`default_nettype wire

// ### sensor_fault_diagnostics_properties.sv
// Concurrent checks on the fault supervisor's diagnostic outputs.
// Assumes binding into sensor_fault_diagnostics; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
// ****************
// Checker
// ****************
module sensor_fault_diagnostics_properties #(
  parameter [23:0] OV_DELAY = 24'h00_000a,
  parameter [23:0] UV_DELAY = 24'h00_000a
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic undervoltage_det,
  input wire logic overvoltage_det,
  input wire logic ground_open_det,
  input wire logic diag_force_high,
  input wire logic output_hiz,
  input wire logic ecc_flag
);
  logic [24:0] idle_q;
  // Cycles of diagnostic drive with no cause left; bounds the release wait
  always @(posedge core_clk) begin
    if (rst || undervoltage_det || overvoltage_det || ground_open_det || !diag_force_high) begin
      idle_q <= 25'h000_0000;
    end else begin
      idle_q <= idle_q + 25'h000_0001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_uv_forces_high: assert property (undervoltage_det && !output_hiz |-> ##[1:3] diag_force_high)
    else $error("undervoltage did not force output");
  a_ov_forces_high: assert property (overvoltage_det && !output_hiz |-> ##[1:3] diag_force_high)
    else $error("overvoltage did not force output");
  a_gnd_forces_high: assert property (ground_open_det && !output_hiz |-> ##[1:3] diag_force_high)
    else $error("open ground did not force output");
  a_uv_release_wait: assert property ($fell(undervoltage_det) && !output_hiz |-> diag_force_high [*4])
    else $error("undervoltage release too early");
  a_ov_release_wait: assert property ($fell(overvoltage_det) && !output_hiz |-> diag_force_high [*4])
    else $error("overvoltage release too early");
  a_hiz_blocks_drive: assert property (output_hiz |=> !diag_force_high)
    else $error("diagnostic drive while floating");
  // Drive with no cause left must end within both delays plus 8 cycles
  a_diag_release_bound: assert property (idle_q <= OV_DELAY + UV_DELAY + 24'h00_0008)
    else $error("diagnostic drive held without cause");
  a_hiz_stays_set: assert property (output_hiz |=> output_hiz)
    else $error("float state dropped");
  a_hiz_sets_flag: assert property (output_hiz |-> ##[0:2] ecc_flag)
    else $error("dual error without flag");
  a_flag_stays_set: assert property (ecc_flag |=> ecc_flag)
    else $error("flag dropped");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !diag_force_high && !output_hiz)
    else $error("outputs active after reset");
endmodule // sensor_fault_diagnostics_properties
bind sensor_fault_diagnostics sensor_fault_diagnostics_properties #(
  .OV_DELAY(OV_DELAY), .UV_DELAY(UV_DELAY)) sensor_fault_diagnostics_properties_i (
  .core_clk(core_clk), .rst(rst), .undervoltage_det(undervoltage_det),
  .overvoltage_det(overvoltage_det), .ground_open_det(ground_open_det),
  .diag_force_high(diag_force_high), .output_hiz(output_hiz), .ecc_flag(ecc_flag));
`default_nettype wire

// ### sensor_fault_diagnostics_bench.sv
// Self-checking bench for the fault supervisor.
// Assumes diag_map.vh on the include path; shortened delays of 10 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "diag_map.vh"
// ****************
// Bench
// ****************
module sensor_fault_diagnostics_bench;
  localparam int DLY = 10;
  logic core_clk = 0, rst = 1, undervoltage_det = 0, overvoltage_det = 0, ground_open_det = 0;
  logic customer_access = 0, factory_access = 0, mem_we = 0, reg_we = 0;
  logic [5:0] mem_waddr = '0, cfg_addr = '0, reg_addr = '0;
  logic [29:0] mem_wdata = '0;
  logic [23:0] reg_wdata = '0, d;
  wire [23:0] reg_rdata, cfg_data;
  wire diag_force_high, output_hiz, ecc_flag;
  int n_fail = 0, n_tests = 0;
  always #2 core_clk = ~core_clk;
  sensor_fault_diagnostics #(.WORDS(4), .OV_DELAY(24'h00_000a), .UV_DELAY(24'h00_000a))
    sensor_fault_diagnostics_i (.core_clk, .rst, .undervoltage_det, .overvoltage_det,
    .ground_open_det, .customer_access, .factory_access, .mem_we, .mem_waddr, .mem_wdata,
    .cfg_addr, .reg_we, .reg_addr, .reg_wdata, .reg_rdata, .cfg_data, .diag_force_high,
    .output_hiz, .ecc_flag);
  // Inputs move 1 ns after the edge, outputs are read there too
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic test_done();
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic give_up(int i);
    if (i >= 200) begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      test_done();
    end
  endtask
  task automatic chk1(logic got, logic exp, string m);
    n_tests++;
    if (got !== exp) begin n_fail++; $display("[ERR] %0t %s", $time, m); end
  endtask
  task automatic chk24(logic [23:0] got, logic [23:0] exp, string m);
    n_tests++;
    if (got !== exp) begin n_fail++; $display("[ERR] %0t %s %h", $time, m, got); end
  endtask
  task automatic wr(logic [5:0] a, logic [23:0] v);
    reg_addr = a; reg_wdata = v; reg_we = 1; tick(1); reg_we = 0;
  endtask
  task automatic rd(logic [5:0] a);
    reg_addr = a; tick(1); d = reg_rdata;
  endtask
  task automatic mw(logic [5:0] a, logic [29:0] v);
    mem_waddr = a; mem_wdata = v; mem_we = 1; tick(1); mem_we = 0; tick(1);
  endtask
  // One supply or ground fault: forced, a supply fault checked still held DLY - 3 cycles after release, then freed
  task automatic t_supply(int k);
    int i;
    {ground_open_det, overvoltage_det, undervoltage_det} = 3'b001 << k;
    tick(3); chk1(diag_force_high, 1, "not forced");
    {ground_open_det, overvoltage_det, undervoltage_det} = 3'b000;
    if (k < 2) begin tick(DLY - 3); chk1(diag_force_high, 1, "freed early"); end
    for (i = 0; i < 200 && diag_force_high !== 1'b0; i++) tick(1);
    give_up(i);
  endtask
  // Margin run under one access kind; busy bit, then both result words
  task automatic t_margin(logic [1:0] sc, logic fac, logic [23:0] mexp, logic [23:0] eexp);
    int i;
    customer_access = !fac; factory_access = fac;
    wr(`REG_TEST_CTRL, {21'h0, sc, 1'b1});
    rd(`REG_TEST_CTRL); chk1(d[0], 1, "run bit not held");
    for (i = 0; i < 200 && d[0] !== 1'b0; i++) rd(`REG_TEST_CTRL);
    give_up(i);
    rd(`REG_MARGIN_FAIL); chk24(d, mexp, "margin result");
    rd(`REG_ECC_FAIL); chk24(d, eexp, "ecc result");
    chk1(diag_force_high, 0, "margin drove output");
  endtask
  // A codeword with bits flipped; one flip is mended, two float the output
  task automatic t_ecc(logic [29:0] cw, logic [29:0] flp, logic [23:0] exp, logic hz);
    mw(6'h01, cw ^ flp); cfg_addr = 6'h01; tick(3);
    if (!hz) chk24(cfg_data, exp, "not corrected");
    chk1(ecc_flag, 1, "flag"); chk1(output_hiz, hz, "float");
  endtask
  initial begin
    tick(8); rst = 0;
    chk1(output_hiz, 0, "reset float");
    chk1(ecc_flag, 0, "reset flag");
    for (int w = 0; w < 4; w++) mw(w[5:0], 30'h0000_0000);
    wr(`REG_ECC_FAIL, 24'hff_ffff); rd(`REG_ECC_FAIL); chk24(d, 24'h00_0000, "ro write");
    t_supply(0);
    t_supply(1);
    t_supply(2);
    // No access granted: the start is ignored
    wr(`REG_TEST_CTRL, 24'h00_0001); rd(`REG_TEST_CTRL); chk1(d[0], 0, "start without access");
    t_margin(`SCOPE_BOTH, 0, 24'h00_0000, 24'h00_0000);
    t_margin(`SCOPE_ONES, 1, 24'h00_0000, 24'h00_0000);
    t_margin(`SCOPE_ZEROS, 0, 24'h00_0000, 24'h00_0000);
    chk1(ecc_flag, 0, "clean flag");
    // Data 1: check bits on positions 1 and 2, parity bit set; data bit 5 flipped high
    t_ecc(30'h2300_0001, 30'h0000_0020, 24'h00_0001, 0);
    t_margin(`SCOPE_ONES, 0, 24'h00_0000, 24'h00_0002);
    t_margin(`SCOPE_ZEROS, 1, 24'h00_0002, 24'h00_0002);
    t_ecc(30'h2300_0001, 30'h0000_0030, 24'h00_0000, 1);
    overvoltage_det = 1; tick(4); chk1(output_hiz, 1, "float lost");
    chk1(diag_force_high, 0, "drive over float");
    test_done();
  end
endmodule // sensor_fault_diagnostics_bench
`default_nettype wire
